/* File: src/dct_pkg.sv */
/*
 * Constants, field layout and carrier types of the down-count timer block.
 * Assumes a classic Wishbone master with 32-bit data and byte addresses;
 * every timer register is one byte in the low lane of an aligned word.
 */
package dct_pkg;

    // Register byte addresses
    localparam logic [7:0] DCT_ADR_TX_LO  = 8'h00;
    localparam logic [7:0] DCT_ADR_TX_HI  = 8'h04;
    localparam logic [7:0] DCT_ADR_TY_LO  = 8'h08;
    localparam logic [7:0] DCT_ADR_TY_HI  = 8'h0C;
    localparam logic [7:0] DCT_ADR_T1     = 8'h10;
    localparam logic [7:0] DCT_ADR_T2     = 8'h14;
    localparam logic [7:0] DCT_ADR_T3     = 8'h18;
    localparam logic [7:0] DCT_ADR_TXMODE = 8'h1C;
    localparam logic [7:0] DCT_ADR_CTRL   = 8'h20;
    localparam logic [7:0] DCT_ADR_IRQ    = 8'h24;

    // Timer X mode register fields, and the control register's low-speed bit
    localparam int DCT_MODE_LSB   = 0;
    localparam int DCT_WCTL_BIT   = 2;
    localparam int DCT_RTPEN_BIT  = 3;
    localparam int DCT_EDGE_BIT   = 4;
    localparam int DCT_RTP_LSB    = 5;
    localparam int DCT_LOWSPD_BIT = 0;

    // Interrupt request bit positions
    localparam int DCT_IRQ_W    = 6;
    localparam int DCT_IRQ_TX   = 0;
    localparam int DCT_IRQ_TY   = 1;
    localparam int DCT_IRQ_T1   = 2;
    localparam int DCT_IRQ_T2   = 3;
    localparam int DCT_IRQ_T3   = 4;
    localparam int DCT_IRQ_CNTR = 5;

    // Reset values and timing
    localparam logic [7:0]  DCT_TXMODE_RST = 8'h00;
    localparam logic [7:0]  DCT_CTRL_RST   = 8'h00;
    localparam logic [15:0] DCT_T16_RST    = 16'hFFFF;
    localparam logic [7:0]  DCT_T8_RST     = 8'hFF;
    localparam int          DCT_PRESC_DIV  = 16;

    typedef enum logic [1:0] {
        DCT_MODE_TIMER,
        DCT_MODE_PULSE,
        DCT_MODE_EVENT,
        DCT_MODE_PWM
    } dct_mode_type;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } dct_wb_req_type;

endpackage

/* File: src/dct_timers.sv */
/*
 * Five down-count timers (two 16-bit, three 8-bit) with reload latches,
 * the primary 16-bit timer's four modes, counter pin, real-time port
 * and interrupt request bits, behind a classic Wishbone slave.
 * Assumes clock_in is the main oscillator clock; the sub-oscillator and
 * counter pin are asynchronous and are synchronised here.
 */

// One down counter with its reload latch
module dct_down_timer #(
    parameter int             W       = 8,
    parameter logic [W-1:0]   RST_VAL = '1
) (
    input  wire logic         clock_in,
    input  wire logic         resetn_in,
    input  wire logic         tick_in,
    input  wire logic         load_cnt_in,
    input  wire logic         load_lat_in,
    input  wire logic [W-1:0] value_in,
    output logic      [W-1:0] count_out,
    output logic      [W-1:0] latch_out,
    output logic              uflow_out
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic [W-1:0] lat_q;
    logic [W-1:0] lat_d;

    // Underflow is the count pulse that finds zero; reload, keep running
    assign uflow_out = tick_in && (count_q == '0);                 // [R02]
    assign count_d   = load_cnt_in ? value_in :
                       uflow_out   ? lat_q :                       // [R02]
                       tick_in     ? count_q - 1'b1 : count_q;
    assign lat_d     = load_lat_in ? value_in : lat_q;
    assign count_out = count_q;
    assign latch_out = lat_q;

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            count_q <= RST_VAL;
            lat_q   <= RST_VAL;
        end else begin
            count_q <= count_d;
            lat_q   <= lat_d;
        end
    end
endmodule

// Operation
// R01: Five timers, two 16-bit and three 8-bit, each with a reload latch.
// R02: Timers count down; count pulse at zero underflows, reloads, continues.
// R03: Each underflow sets that timer's own interrupt request bit.
// R04: Software reads and writes both bytes of 16-bit timers, reading high first.
// R05: Software writes the low byte of a 16-bit timer before the high.
// R06: Software never mixes a paired read with a paired write.
// R07: Mode register picks four modes, write control and real-time port.
// R08: Timer mode counts main clock /16, or sub-clock /16 at low speed.
// R09: Pulse output mode toggles the counter pin at every underflow.
// R10: Event counter mode counts counter pin pulses instead of the clock.
// R11: Pulse width mode counts only while pin high (edge 0) or low (1).
// R12: Write control 0: a write loads both count and latch.
// R13: Write control 1: a write loads latch only; count takes it at underflow.
// R14: Software avoids writing the high latch byte right at underflow.
// R15: Changing the pin's active edge may set its request; software clears it.
// R16: Counter pin request edge follows the active edge select bit.
// R17: Event mode counts synchronised pin edges chosen by the edge bit.
module dct_timers
    import dct_pkg::*;
#(
    parameter int PRESC_DIV = DCT_PRESC_DIV
) (
    input  wire logic                 clock_in,
    input  wire logic                 resetn_in,
    input  wire logic                 ce_in,
    input  wire dct_wb_req_type       wb_req_in,
    output logic                      wb_ack_out,
    output logic [31:0]               wb_dat_out,
    input  wire logic                 sub_oscillator_input_in,
    input  wire logic                 timer_x_counter_pin_in,
    output logic                      timer_x_counter_pin_out,
    output logic                      timer_x_counter_pin_oe_out,
    output logic [1:0]                rtp_out,
    output logic [DCT_IRQ_W-1:0]      irq_req_out
);
    localparam int         PW        = $clog2(PRESC_DIV);
    localparam logic [PW-1:0] PRESC_MAX = PW'(PRESC_DIV - 1);
    localparam logic [PW:0]   GAP_MIN   = (PW+1)'(PRESC_DIV - 1);

    if (PRESC_DIV < 2) begin : g_bad_presc
        $error("PRESC_DIV must be at least 2");
    end

    // Bus state and outputs
    logic                 ack_q;
    logic [31:0]          dat_q;
    logic [7:0]           rd_byte;
    logic                 req;
    logic                 acc;
    logic                 wr;
    logic                 rd;
    logic [7:0]           wd;
    logic [7:0]           adr;

    // Control registers and timer state
    logic [7:0]           txmode_q;
    logic [7:0]           ctrl_q;
    logic [DCT_IRQ_W-1:0] irq_q;
    logic [DCT_IRQ_W-1:0] irq_set;
    logic [DCT_IRQ_W-1:0] irq_keep;
    logic [7:0]           txlo_wbuf_q;
    logic [7:0]           tylo_wbuf_q;
    logic [7:0]           txlo_rbuf_q;
    logic [7:0]           tylo_rbuf_q;
    logic [1:0]           rtp_q;
    logic                 pin_out_q;
    logic                 pin_oe_q;
    logic [PW-1:0]        presc_q;
    logic                 sub_s1_q;
    logic                 sub_s2_q;
    logic                 sub_s3_q;
    logic                 pin_s1_q;
    logic                 pin_s2_q;
    logic                 pin_lvl_q;
    logic [PW:0]          gap_q;

    logic                 presc_src;
    logic                 presc_tick;
    logic                 pin_lvl;
    logic                 pin_evt;
    logic                 tx_tick;
    dct_mode_type         tx_mode;
    logic                 edge_sel;
    logic                 wctl;
    logic                 rtp_en;
    logic                 rtp_rise;
    logic                 tx_commit;
    logic                 ty_commit;
    logic [15:0]          tx_cnt;
    logic [15:0]          tx_lat;
    logic [15:0]          ty_cnt;
    logic [7:0]           t1_cnt;
    logic [7:0]           t2_cnt;
    logic [7:0]           t3_cnt;
    logic                 tx_uf;
    logic                 ty_uf;
    logic                 t1_uf;
    logic                 t2_uf;
    logic                 t3_uf;

    // Bus decode: one access per request, answered the next cycle
    assign req = wb_req_in.cyc & wb_req_in.stb;
    assign acc = ce_in & req & ~ack_q;
    assign wr  = acc & wb_req_in.we & wb_req_in.sel[0];
    assign rd  = acc & ~wb_req_in.we;
    assign wd  = wb_req_in.dat[7:0];
    assign adr = wb_req_in.adr;

    // Mode register fields
    assign tx_mode  = dct_mode_type'(txmode_q[DCT_MODE_LSB +: 2]);   // [R07]
    assign wctl     = txmode_q[DCT_WCTL_BIT];
    assign rtp_en   = txmode_q[DCT_RTPEN_BIT];
    assign edge_sel = txmode_q[DCT_EDGE_BIT];
    assign rtp_rise = wr & (adr == DCT_ADR_TXMODE) & wd[DCT_RTPEN_BIT]
                      & ~rtp_en;

    // Paired 16-bit writes commit on the high byte; low byte is parked
    assign tx_commit = wr & (adr == DCT_ADR_TX_HI);
    assign ty_commit = wr & (adr == DCT_ADR_TY_HI);

    // Read selection; the low byte comes from the copy taken at high read
    assign rd_byte = (adr == DCT_ADR_TX_HI)  ? tx_cnt[15:8] :
                     (adr == DCT_ADR_TX_LO)  ? txlo_rbuf_q :
                     (adr == DCT_ADR_TY_HI)  ? ty_cnt[15:8] :
                     (adr == DCT_ADR_TY_LO)  ? tylo_rbuf_q :
                     (adr == DCT_ADR_T1)     ? t1_cnt :
                     (adr == DCT_ADR_T2)     ? t2_cnt :
                     (adr == DCT_ADR_T3)     ? t3_cnt :
                     (adr == DCT_ADR_TXMODE) ? txmode_q :
                     (adr == DCT_ADR_CTRL)   ? ctrl_q :
                     (adr == DCT_ADR_IRQ)    ? {2'h0, irq_q} : 8'h00;

    // Count source: every clock, or sub-clock rising edges at low speed
    assign presc_src  = ctrl_q[DCT_LOWSPD_BIT] ? (sub_s2_q & ~sub_s3_q)
                                               : 1'b1;
    assign presc_tick = ce_in & presc_src & (presc_q == PRESC_MAX); // [R08]

    // Pin level seen through the edge select; its rise is the active edge,
    // so flipping the select alone can raise a request too
    assign pin_lvl = pin_s2_q ^ edge_sel;                           // [R16]
    assign pin_evt = ce_in & pin_lvl & ~pin_lvl_q;                  // [R15]

    // Primary timer count pulse per mode
    always_comb begin
        unique case (tx_mode)
            DCT_MODE_TIMER: tx_tick = presc_tick;                    // [R08]
            DCT_MODE_PULSE: tx_tick = presc_tick;                    // [R09]
            DCT_MODE_EVENT: tx_tick = pin_evt;                 // [R10] [R17]
            DCT_MODE_PWM:   tx_tick = presc_tick & pin_lvl;          // [R11]
        endcase
    end

    // Five counters, each with its own latch
    dct_down_timer #(.W(16), .RST_VAL(DCT_T16_RST)) u_tx (           // [R01]
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .tick_in     (tx_tick),
        .load_cnt_in (tx_commit & ~wctl),                            // [R12]
        .load_lat_in (tx_commit),                                    // [R13]
        .value_in    ({wd, txlo_wbuf_q}),
        .count_out   (tx_cnt),
        .latch_out   (tx_lat),
        .uflow_out   (tx_uf)
    );
    dct_down_timer #(.W(16), .RST_VAL(DCT_T16_RST)) u_ty (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .tick_in     (presc_tick),
        .load_cnt_in (ty_commit),
        .load_lat_in (ty_commit),
        .value_in    ({wd, tylo_wbuf_q}),
        .count_out   (ty_cnt),
        .latch_out   (),
        .uflow_out   (ty_uf)
    );
    dct_down_timer #(.W(8), .RST_VAL(DCT_T8_RST)) u_t1 (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .tick_in     (presc_tick),
        .load_cnt_in (wr & (adr == DCT_ADR_T1)),
        .load_lat_in (wr & (adr == DCT_ADR_T1)),
        .value_in    (wd),
        .count_out   (t1_cnt),
        .latch_out   (),
        .uflow_out   (t1_uf)
    );
    dct_down_timer #(.W(8), .RST_VAL(DCT_T8_RST)) u_t2 (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .tick_in     (presc_tick),
        .load_cnt_in (wr & (adr == DCT_ADR_T2)),
        .load_lat_in (wr & (adr == DCT_ADR_T2)),
        .value_in    (wd),
        .count_out   (t2_cnt),
        .latch_out   (),
        .uflow_out   (t2_uf)
    );
    dct_down_timer #(.W(8), .RST_VAL(DCT_T8_RST)) u_t3 (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .tick_in     (presc_tick),
        .load_cnt_in (wr & (adr == DCT_ADR_T3)),
        .load_lat_in (wr & (adr == DCT_ADR_T3)),
        .value_in    (wd),
        .count_out   (t3_cnt),
        .latch_out   (),
        .uflow_out   (t3_uf)
    );

    // Request bits: software clears by writing 0, an event in the same
    // cycle still sets, so no underflow is lost
    assign irq_set  = {pin_evt, t3_uf, t2_uf, t1_uf, ty_uf, tx_uf};  // [R03]
    assign irq_keep = (wr & (adr == DCT_ADR_IRQ)) ? wd[DCT_IRQ_W-1:0]
                                                  : '1;

    // Bus answer and software-visible registers
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            ack_q       <= 1'b0;
            dat_q       <= 32'h0000_0000;
            txmode_q    <= DCT_TXMODE_RST;
            ctrl_q      <= DCT_CTRL_RST;
            irq_q       <= '0;
            txlo_wbuf_q <= 8'h00;
            tylo_wbuf_q <= 8'h00;
            txlo_rbuf_q <= 8'h00;
            tylo_rbuf_q <= 8'h00;
        end else if (ce_in) begin
            ack_q <= req & ~ack_q;
            if (acc) begin
                dat_q <= {24'h00_0000, rd_byte};
            end
            if (wr & (adr == DCT_ADR_TXMODE)) begin
                txmode_q <= wd;
            end
            if (wr & (adr == DCT_ADR_CTRL)) begin
                ctrl_q <= wd;
            end
            if (wr & (adr == DCT_ADR_TX_LO)) begin
                txlo_wbuf_q <= wd;
            end
            if (wr & (adr == DCT_ADR_TY_LO)) begin
                tylo_wbuf_q <= wd;
            end
            if (rd & (adr == DCT_ADR_TX_HI)) begin
                txlo_rbuf_q <= tx_cnt[7:0];
            end
            if (rd & (adr == DCT_ADR_TY_HI)) begin
                tylo_rbuf_q <= ty_cnt[7:0];
            end
            irq_q <= (irq_q & irq_keep) | irq_set;                   // [R03]
        end
    end

    // Synchronisers, prescaler, counter pin and real-time port
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            sub_s1_q  <= 1'b0;
            sub_s2_q  <= 1'b0;
            sub_s3_q  <= 1'b0;
            pin_s1_q  <= 1'b0;
            pin_s2_q  <= 1'b0;
            pin_lvl_q <= 1'b0;
            presc_q   <= '0;
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
            rtp_q     <= 2'h0;
        end else if (ce_in) begin
            sub_s1_q  <= sub_oscillator_input_in;
            sub_s2_q  <= sub_s1_q;
            sub_s3_q  <= sub_s2_q;
            pin_s1_q  <= timer_x_counter_pin_in;
            pin_s2_q  <= pin_s1_q;
            pin_lvl_q <= pin_lvl;
            if (presc_src) begin
                presc_q <= (presc_q == PRESC_MAX) ? '0 : presc_q + 1'b1;
            end
            // Pin is driven only in pulse output mode
            pin_oe_q <= (tx_mode == DCT_MODE_PULSE);
            if (tx_uf && tx_mode == DCT_MODE_PULSE) begin
                pin_out_q <= ~pin_out_q;                             // [R09]
            end
            if ((tx_uf && rtp_en) || rtp_rise) begin
                rtp_q <= rtp_rise ? wd[DCT_RTP_LSB +: 2]
                                  : txmode_q[DCT_RTP_LSB +: 2];
            end
        end
    end

    assign wb_ack_out                 = ack_q;
    assign wb_dat_out                 = dat_q;
    assign timer_x_counter_pin_out    = pin_out_q;
    assign timer_x_counter_pin_oe_out = pin_oe_q;
    assign rtp_out                    = rtp_q;
    assign irq_req_out                = irq_q;

    // Enabled cycles since the last count-source tick, saturating, so the
    // spacing check works for any divide ratio and at low speed too
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            gap_q <= '0;
        end else if (presc_tick) begin
            gap_q <= '0;
        end else if (ce_in && gap_q != GAP_MIN) begin
            gap_q <= gap_q + 1'b1;
        end
    end

    chk_tx_reload: assert property (@(posedge clock_in) // [R02]
        disable iff (!resetn_in) tx_uf && !tx_commit |=> tx_cnt == $past(tx_lat))
        else $error("timer X did not reload from its latch");
    chk_tx_request: assert property (@(posedge clock_in) // [R03]
        disable iff (!resetn_in) tx_uf |=> irq_q[DCT_IRQ_TX])
        else $error("timer X underflow did not set its request");
    chk_t1_request: assert property (@(posedge clock_in) // [R03]
        disable iff (!resetn_in) t1_uf |=> irq_q[DCT_IRQ_T1] && irq_req_out[2])
        else $error("timer 1 underflow did not set its request");
    chk_presc_spacing: assert property (@(posedge clock_in) // [R08]
        disable iff (!resetn_in) presc_tick |-> gap_q == GAP_MIN)
        else $error("count source ticks closer than its divide ratio");
    chk_pulse_toggle: assert property (@(posedge clock_in) // [R09]
        disable iff (!resetn_in) tx_uf && tx_mode == DCT_MODE_PULSE
        |=> timer_x_counter_pin_out != $past(timer_x_counter_pin_out))
        else $error("counter pin did not toggle at underflow");
    chk_event_count: assert property (@(posedge clock_in) // [R17]
        disable iff (!resetn_in) tx_mode == DCT_MODE_EVENT && pin_evt
        && !tx_commit && tx_cnt != 16'h0000 |=> tx_cnt == $past(tx_cnt) - 1)
        else $error("event edge did not decrement timer X");
    chk_pwm_hold: assert property (@(posedge clock_in) // [R11]
        disable iff (!resetn_in) tx_mode == DCT_MODE_PWM && !pin_lvl
        && !tx_commit |=> $stable(tx_cnt))
        else $error("timer X counted while pin inactive");
    chk_write_both: assert property (@(posedge clock_in) // [R12]
        disable iff (!resetn_in) tx_commit && !wctl
        |=> tx_cnt == tx_lat && tx_lat == $past({wd, txlo_wbuf_q}))
        else $error("write did not load count and latch");
    chk_write_latch: assert property (@(posedge clock_in) // [R13]
        disable iff (!resetn_in) tx_commit && wctl && !tx_tick
        |=> $stable(tx_cnt) && tx_lat == $past({wd, txlo_wbuf_q}))
        else $error("latch-only write disturbed the count");
    chk_pin_request: assert property (@(posedge clock_in) // [R16]
        disable iff (!resetn_in) pin_evt |=> irq_q[DCT_IRQ_CNTR])
        else $error("counter pin edge did not set its request");
endmodule

/* File: tb/dct_pin_model.sv */
/*
 * Far side of the counter pin: a pulse source, or a plain load while the
 * timer drives the pin.
 * Assumes the bench calls pulse() and shares the timer's clock.
 */
module dct_pin_model (
    input  wire logic clock_in,
    input  wire logic pin_drive_in,
    input  wire logic pin_oe_in,
    output logic      pin_level_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic src_q = 1'b0;

    // Wire level: the timer wins while it drives, else our source
    assign pin_level_out = pin_oe_in ? pin_drive_in : src_q;

    // Six cycles a phase, well past the two-flop sync on the timer side
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock_in);
            src_q <= 1'b1;
            repeat (6) @(posedge clock_in);
            src_q <= 1'b0;
            repeat (6) @(posedge clock_in);
        end
    endtask
endmodule

/* File: tb/down_count_timers_timer_x_tb.sv */
/*
 * Self-checking bench of the down-count timers over classic Wishbone.
 * Assumes the counter pin model beside it and a short prescaler.
 */
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module down_count_timers_timer_x_tb;
    import dct_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int PRESC = 2;
    logic                 clock_in;
    logic                 resetn_in;
    logic                 ce;
    logic                 sub_clk;
    dct_wb_req_type       req;
    logic                 wb_ack;
    logic [31:0]          wb_dat;
    logic                 pin_out;
    logic                 pin_oe;
    logic                 pin_lvl;
    logic [1:0]           rtp;
    logic [DCT_IRQ_W-1:0] irq;
    logic [31:0]          r;
    logic [15:0]          v;
    int                   n;
    logic                 pin_hold;
    int                   n_errors = 0;
    int                   comparisons = 0;

    dct_timers #(.PRESC_DIV(PRESC)) i_dut (
        .clock_in(clock_in), .resetn_in(resetn_in), .ce_in(ce),
        .wb_req_in(req), .wb_ack_out(wb_ack), .wb_dat_out(wb_dat),
        .sub_oscillator_input_in(sub_clk),
        .timer_x_counter_pin_in(pin_lvl),
        .timer_x_counter_pin_out(pin_out),
        .timer_x_counter_pin_oe_out(pin_oe),
        .rtp_out(rtp), .irq_req_out(irq));

    dct_pin_model i_pin (
        .clock_in(clock_in), .pin_drive_in(pin_out),
        .pin_oe_in(pin_oe), .pin_level_out(pin_lvl));

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    task automatic final_report();
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clock_in);
        req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
        do begin
            @(posedge clock_in);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        q = wb_dat;
        req <= '0;
        if (k >= 50) begin
            n_errors++;
            $display("[FAIL] %0t no ack", $time);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    // Pairs never interleave; low byte goes first
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 8'h04, d[15:8]);
    endtask

    // High byte first, it snaps the low byte
    task automatic rd16(input logic [7:0] a, output logic [15:0] d);
        logic [31:0] q;
        wb(1'b0, a + 8'h04, 8'h00, q);
        d[15:8] = q[7:0];
        wb(1'b0, a, 8'h00, q);
        d[7:0] = q[7:0];
    endtask

    // Cycles until the pin level next changes, bounded
    task automatic wait_pin(output int k);
        logic p;
        p = pin_out;
        k = 0;
        do begin
            @(posedge clock_in);
            k++;
        end while (pin_out === p && k < 200);
    endtask

    // Main sequence
    initial begin
        resetn_in = 1'b0;
        sub_clk = 1'b0;
        ce = 1'b1;
        req = '0;
        repeat (2) @(posedge clock_in);
        resetn_in <= 1'b1;
        wb(1'b0, DCT_ADR_TXMODE, 8'h00, r);
        `CHK(r, {24'h0, DCT_TXMODE_RST})
        wr(8'h30, 8'h5A);
        wb(1'b0, 8'h30, 8'h00, r);
        `CHK(r, 32'h0000_0000)
        // Event counting, rising then falling edges
        wr(DCT_ADR_TXMODE, 8'h02);
        wr16(DCT_ADR_TX_LO, 16'h1234);
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v, 16'h1234)
        wr(DCT_ADR_IRQ, 8'h00);
        i_pin.pulse(3);
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v, 16'h1231)
        wb(1'b0, DCT_ADR_IRQ, 8'h00, r);
        `CHK(r[DCT_IRQ_CNTR], 1'b1)
        // Flipping the select with the pin steady is itself an active
        // edge: it raises the request and counts once
        wr(DCT_ADR_IRQ, 8'h00);
        wr(DCT_ADR_TXMODE, 8'h12);
        wb(1'b0, DCT_ADR_IRQ, 8'h00, r);
        `CHK(r[DCT_IRQ_CNTR], 1'b1)
        wr(DCT_ADR_IRQ, 8'h00);
        wb(1'b0, DCT_ADR_IRQ, 8'h00, r);
        `CHK(r[DCT_IRQ_CNTR], 1'b0)
        i_pin.pulse(2);
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v, 16'h122E)
        wb(1'b0, DCT_ADR_IRQ, 8'h00, r);
        `CHK(r[DCT_IRQ_CNTR], 1'b1)
        // Underflow at zero reloads and raises the request
        wr16(DCT_ADR_TX_LO, 16'h0001);
        wr(DCT_ADR_IRQ, 8'h00);
        i_pin.pulse(1);
        wb(1'b0, DCT_ADR_IRQ, 8'h00, r);
        `CHK(r[DCT_IRQ_TX], 1'b0)
        i_pin.pulse(1);
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v, 16'h0001)
        wb(1'b0, DCT_ADR_IRQ, 8'h00, r);
        `CHK(r[DCT_IRQ_TX], 1'b1)
        // Latch-only writes wait for the next underflow
        wr(DCT_ADR_TXMODE, 8'h16);
        wr16(DCT_ADR_TX_LO, 16'h0005);
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v, 16'h0001)
        i_pin.pulse(2);
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v, 16'h0005)
        // Pulse output with the real-time port enabled
        wr(DCT_ADR_TXMODE, 8'h49);
        `CHK(rtp, 2'b10)
        wr16(DCT_ADR_TX_LO, 16'h0003);
        `CHK(pin_oe, 1'b1)
        wait_pin(n);
        wait_pin(n);
        `CHK(n, 4 * PRESC)
        // New port data waits for the next underflow
        wr(DCT_ADR_TXMODE, 8'h29);
        wait_pin(n);
        `CHK(rtp, 2'b01)
        // Clock enable low freezes the count, so the pin holds its level
        ce <= 1'b0;
        pin_hold = pin_out;
        repeat (20) @(posedge clock_in);
        `CHK(pin_out, pin_hold)
        ce <= 1'b1;
        // Pulse width: pin held low by the model
        wr(DCT_ADR_TXMODE, 8'h03);
        wr16(DCT_ADR_TX_LO, 16'h0100);
        repeat (40) @(posedge clock_in);
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v, 16'h0100)
        wr(DCT_ADR_TXMODE, 8'h13);
        repeat (40) @(posedge clock_in);
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v < 16'h0100 && v >= 16'h00E0, 1'b1)
        // Low speed: only the sub-clock moves the count
        wr(DCT_ADR_CTRL, 8'h01);
        wr(DCT_ADR_TXMODE, 8'h00);
        wr16(DCT_ADR_TX_LO, 16'h0050);
        repeat (40) @(posedge clock_in);
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v, 16'h0050)
        repeat (80) begin
            repeat (3) @(posedge clock_in);
            sub_clk <= ~sub_clk;
        end
        rd16(DCT_ADR_TX_LO, v);
        `CHK(v, 16'h0050 - 16'(40 / PRESC))
        wr(DCT_ADR_CTRL, 8'h00);
        // The other four timers underflow and raise their own bits
        wr16(DCT_ADR_TY_LO, 16'h0002);
        wr(DCT_ADR_T1, 8'h02);
        wr(DCT_ADR_T2, 8'h02);
        wr(DCT_ADR_T3, 8'h02);
        wr(DCT_ADR_IRQ, 8'h00);
        repeat (40) @(posedge clock_in);
        wb(1'b0, DCT_ADR_IRQ, 8'h00, r);
        `CHK(r[4:1], 4'hF)
        wb(1'b0, DCT_ADR_T2, 8'h00, r);
        `CHK(r[7:0] <= 8'h02, 1'b1)
        // Reset in mid-run returns outputs and registers to rest
        resetn_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        resetn_in <= 1'b1;
        `CHK(irq, {DCT_IRQ_W{1'b0}})
        `CHK(rtp, 2'b00)
        wb(1'b0, DCT_ADR_TXMODE, 8'h00, r);
        `CHK(r, {24'h0, DCT_TXMODE_RST})
        final_report();
    end

    // Watchdog, far beyond the less than a thousand cycles the run needs
    initial begin
        #(30000 * 100);
        n_errors++;
        $display("[FAIL] %0t watchdog", $time);
        final_report();
    end
endmodule
